//--- core/uvcr_defs.vh
/*
 * Constants for the vendor control register bank: register addresses,
 * field positions, reset values and the conversion time.
 * Assumes a 100 MHz register clock and a 6-bit ULPI register address.
 */
// Contract
// RULE1: Vendor range reached by ordinary immediate accesses
// RULE2: Link clears charger enables before USB use
// RULE3: Sink bit gates comparator; clear forces zero
// RULE4: Host port bit swaps charger connections
// RULE5: Detect bit needs voltage and linestate zero
// RULE6: Detect flag mirrored in carkit status
// RULE7: ID register at write, set, clear addresses
// RULE8: Bits 2:0 hold ID resistor code
// RULE9: Done sets after 282 us, mirrored
// RULE10: Reading ID register clears done flag
// RULE11: Carkit read leaves done flag alone
// RULE12: Go bit starts conversion, self-clears
// RULE13: Link keeps bit 5 zero
// RULE14: Enabled done raises alt interrupt
// RULE15: Interrupt enable ORs carkit enable
// RULE16: IO register at write, set, clear addresses
// RULE17: Swap bit exchanges data pins
// RULE18: UART regulator level applies at transmit enable
// RULE19: USB regulator level in other modes
// RULE20: Charger pull-ups, forced on in UART
// RULE21: Set ORs byte, clear removes ones
`ifndef UVCR_DEFS_VH
`define UVCR_DEFS_VH

// Register addresses
`define UVCR_ADDR_CHG      6'h32
`define UVCR_ADDR_ID_WR    6'h36
`define UVCR_ADDR_ID_SET   6'h37
`define UVCR_ADDR_ID_CLR   6'h38
`define UVCR_ADDR_IO_WR    6'h39
`define UVCR_ADDR_IO_SET   6'h3a
`define UVCR_ADDR_IO_CLR   6'h3b

// Charger detection fields
`define UVCR_CHG_SRC       0
`define UVCR_CHG_SINK      1
`define UVCR_CHG_CONTACT   2
`define UVCR_CHG_HOST      3
`define UVCR_CHG_DET       4
`define UVCR_CHG_RST       4'h0

// ID conversion fields
`define UVCR_ID_CODE_LSB   0
`define UVCR_ID_CODE_MSB   2
`define UVCR_ID_DONE       3
`define UVCR_ID_GO         4
`define UVCR_ID_RSVD       5
`define UVCR_ID_IRQEN      6
`define UVCR_ID_WMASK      8'h50
`define UVCR_ID_CODE_ERR   3'h7

// IO and power fields
`define UVCR_IO_SWAP       1
`define UVCR_IO_UREG_LSB   2
`define UVCR_IO_UREG_MSB   3
`define UVCR_IO_PU_DP      4
`define UVCR_IO_PU_DM      5
`define UVCR_IO_SREG_LSB   6
`define UVCR_IO_SREG_MSB   7
`define UVCR_IO_WMASK      8'hfe
`define UVCR_IO_RST        8'h04

// Conversion time
`define UVCR_CONV_US       282
`define UVCR_CLK_MHZ       100
`define UVCR_CONV_CYC      (`UVCR_CONV_US * `UVCR_CLK_MHZ)

`endif

//--- core/uvcr_sync2.v
/*
 * Two-flop synchroniser for a bus of asynchronous levels.
 * Assumes inputs come from analog comparators or pins outside i_mclk.
 */
module uvcr_sync2 #(
    parameter W = 1                   // Bus width
) (
    // Clock and reset
    input  wire         i_mclk,
    input  wire         i_arst_n,
    // Levels
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_r;               // First stage, read only by second
    reg [W-1:0] sync_r;               // Second stage

    // Two stages, constant reset
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule // uvcr_sync2

//--- core/uvcr_conv_timer.v
/*
 * Conversion timer: counts the ID resistor conversion time after a start.
 * Assumes a single-cycle start pulse from the register bank.
 */
`include "uvcr_defs.vh"
module uvcr_conv_timer #(
    parameter CONV_CYC = `UVCR_CONV_CYC // Conversion length in cycles
) (
    // Clock and reset
    input  wire i_mclk,
    input  wire i_arst_n,
    // Control
    input  wire i_start,
    output wire o_busy,
    output reg  o_finish
);
    reg [15:0] cnt_r;                 // Remaining cycles
    reg        busy_r;                // Conversion running

    // Count down, pulse finish at end
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r    <= 16'h0000;
            busy_r   <= 1'b0;
            o_finish <= 1'b0;
        end else begin
            o_finish <= 1'b0;
            if (i_start && !busy_r) begin
                cnt_r  <= CONV_CYC[15:0] - 16'h0001;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (cnt_r == 16'h0000) begin
                    busy_r   <= 1'b0;
                    o_finish <= 1'b1;   // RULE9
                end else begin
                    cnt_r <= cnt_r - 16'h0001;
                end
            end
        end
    end

    assign o_busy = busy_r;
endmodule // uvcr_conv_timer

//--- core/uvcr_regs.v
/*
 * Vendor control register bank of a ULPI transceiver: charger detection,
 * ID resistor conversion and IO/power management.
 * Assumes the ULPI register engine presents one-cycle write/read strobes
 * with a 6-bit address on i_mclk; analog results arrive asynchronously.
 */
`include "uvcr_defs.vh"
module uvcr_regs #(
    parameter CONV_CYC = `UVCR_CONV_CYC // Conversion length, shortenable
) (
    // Clock and reset
    input  wire       i_mclk,
    input  wire       i_arst_n,
    // Register access from ULPI engine
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    input  wire [5:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    output wire       o_reg_hit,
    // Carkit interrupt side
    input  wire       i_carkit_irq_en,
    input  wire       i_carkit_status_rd,
    output wire       o_carkit_dat_detect,
    output wire [2:0] o_carkit_id_code,
    output wire       o_carkit_id_done,
    output wire       o_alt_int,
    // Mode inputs from the PHY core
    input  wire       i_uart_mode,
    input  wire       i_uart_transmit_path_en,
    input  wire [1:0] i_linestate,
    // Analog inputs
    input  wire       i_dp_voltage_seen,
    input  wire       i_dm_voltage_seen,
    input  wire [2:0] i_id_adc_code,
    // Charger analog controls
    output wire       o_dp_dat_source_voltage_en,
    output wire       o_dm_dat_source_voltage_en,
    output wire       o_dp_dat_sink_en,
    output wire       o_dm_dat_sink_en,
    output wire       o_dp_contact_source_en,
    output wire       o_dm_contact_source_en,
    // ID converter control
    output wire       o_id_conversion_busy,
    // IO and power controls
    output wire       o_data_pin_swap,
    output wire       o_dp_charger_pullup_en,
    output wire       o_dm_charger_pullup_en,
    output reg  [1:0] o_regulator_level
);
    // Register storage
    reg  [3:0] chg_r;                 // Charger enables
    reg  [7:0] id_r;                  // ID conversion register
    reg  [7:0] io_r;                  // IO and power register
    reg  [7:0] id_nxt;                // Next ID register value
    reg  [7:0] io_nxt;                // Next IO register value
    reg        uart_level_live_r;     // UART level taken after transmit enable
    reg        det_r;                 // Registered detect flag

    // Synchronised analog and mode levels
    wire [6:0] sync_w;
    wire       dp_seen_s;
    wire       dm_seen_s;
    wire [2:0] adc_s;
    wire       uart_s;
    wire       txd_s;

    // Conversion timer
    wire       conv_busy;
    wire       conv_finish;
    wire       conv_start;

    // Address decode
    wire       hit_chg;
    wire       hit_id;
    wire       hit_io;

    uvcr_sync2 #(
        .W (7)
    ) u_sync (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_async  ({i_dp_voltage_seen, i_dm_voltage_seen, i_id_adc_code,
                    i_uart_mode, i_uart_transmit_path_en}),
        .o_sync   (sync_w)
    );
    assign dp_seen_s = sync_w[6];
    assign dm_seen_s = sync_w[5];
    assign adc_s     = sync_w[4:2];
    assign uart_s    = sync_w[1];
    assign txd_s     = sync_w[0];

    uvcr_conv_timer #(
        .CONV_CYC (CONV_CYC)
    ) u_timer (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_start  (conv_start),
        .o_busy   (conv_busy),
        .o_finish (conv_finish)
    );

    // Decode the vendor range addresses
    assign hit_chg = (i_reg_addr == `UVCR_ADDR_CHG);                  // RULE1
    assign hit_id  = (i_reg_addr >= `UVCR_ADDR_ID_WR) &&
                     (i_reg_addr <= `UVCR_ADDR_ID_CLR);               // RULE7
    assign hit_io  = (i_reg_addr >= `UVCR_ADDR_IO_WR) &&
                     (i_reg_addr <= `UVCR_ADDR_IO_CLR);               // RULE16
    assign o_reg_hit = hit_chg || hit_id || hit_io;

    // Start on rising go bit while idle
    assign conv_start = id_nxt[`UVCR_ID_GO] && !id_r[`UVCR_ID_GO] && !conv_busy; // RULE12

    // Charger register write
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            chg_r <= `UVCR_CHG_RST;
        end else if (i_reg_wr && hit_chg) begin
            chg_r <= i_reg_wdata[3:0];
        end
    end

    // Detect: sink enabled, voltage on active pin, linestate idle
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            det_r <= 1'b0;
        end else begin
            det_r <= chg_r[`UVCR_CHG_SINK] &&                           // RULE3
                     (chg_r[`UVCR_CHG_HOST] ? dm_seen_s : dp_seen_s) && // RULE4
                     (i_linestate == 2'b00);                            // RULE5
        end
    end
    assign o_carkit_dat_detect = det_r;                                 // RULE6

    // Charger connections, swapped in host port mode
    assign o_dp_dat_source_voltage_en = chg_r[`UVCR_CHG_SRC] && !chg_r[`UVCR_CHG_HOST]; // RULE4
    assign o_dm_dat_source_voltage_en = chg_r[`UVCR_CHG_SRC] &&  chg_r[`UVCR_CHG_HOST];
    assign o_dp_dat_sink_en           = chg_r[`UVCR_CHG_SINK] && !chg_r[`UVCR_CHG_HOST];
    assign o_dm_dat_sink_en           = chg_r[`UVCR_CHG_SINK] &&  chg_r[`UVCR_CHG_HOST];
    assign o_dp_contact_source_en     = chg_r[`UVCR_CHG_CONTACT] && !chg_r[`UVCR_CHG_HOST];
    assign o_dm_contact_source_en     = chg_r[`UVCR_CHG_CONTACT] &&  chg_r[`UVCR_CHG_HOST];

    // ID register next value: write, set or clear access
    always @* begin
        id_nxt = id_r;
        if (i_reg_wr && hit_id) begin
            if (i_reg_addr == `UVCR_ADDR_ID_WR) begin
                id_nxt = (id_r & ~`UVCR_ID_WMASK) | (i_reg_wdata & `UVCR_ID_WMASK);
            end else if (i_reg_addr == `UVCR_ADDR_ID_SET) begin
                id_nxt = id_r | (i_reg_wdata & `UVCR_ID_WMASK);          // RULE21
            end else begin
                id_nxt = id_r & ~(i_reg_wdata & `UVCR_ID_WMASK);         // RULE21
            end
        end
    end

    // ID register update with conversion result and done flag
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            id_r <= 8'h00;
        end else begin
            id_r <= id_nxt;
            // Go bit held by hardware until the conversion ends
            if (conv_busy && !conv_finish) begin
                id_r[`UVCR_ID_GO] <= 1'b1;
            end
            // Reading this register clears done; carkit read does not
            if (i_reg_rd && hit_id) begin
                id_r[`UVCR_ID_DONE] <= 1'b0;                             // RULE10
            end
            // Finish: store code, set done (wins over a clearing read)
            if (conv_finish) begin
                id_r[`UVCR_ID_CODE_MSB:`UVCR_ID_CODE_LSB] <=
                    (adc_s == 3'h6) ? `UVCR_ID_CODE_ERR : adc_s;          // RULE8
                id_r[`UVCR_ID_DONE] <= 1'b1;                             // RULE9
                id_r[`UVCR_ID_GO]   <= 1'b0;                             // RULE12
            end
        end
    end
    assign o_id_conversion_busy = conv_busy;
    assign o_carkit_id_code     = id_r[`UVCR_ID_CODE_MSB:`UVCR_ID_CODE_LSB];
    assign o_carkit_id_done     = id_r[`UVCR_ID_DONE];                   // RULE11

    // Interrupt: enable OR carkit enable, level while done set
    assign o_alt_int = id_r[`UVCR_ID_DONE] &&
                       (id_r[`UVCR_ID_IRQEN] || i_carkit_irq_en);         // RULE14 RULE15

    // IO register next value: write, set or clear access
    always @* begin
        io_nxt = io_r;
        if (i_reg_wr && hit_io) begin
            if (i_reg_addr == `UVCR_ADDR_IO_WR) begin
                io_nxt = i_reg_wdata & `UVCR_IO_WMASK;
            end else if (i_reg_addr == `UVCR_ADDR_IO_SET) begin
                io_nxt = io_r | (i_reg_wdata & `UVCR_IO_WMASK);          // RULE21
            end else begin
                io_nxt = io_r & ~(i_reg_wdata & `UVCR_IO_WMASK);         // RULE21
            end
        end
    end

    // IO register storage
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            io_r <= `UVCR_IO_RST;
        end else begin
            io_r <= io_nxt;
        end
    end

    // UART level becomes live once transmit enable asserts in UART mode
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            uart_level_live_r <= 1'b0;
        end else if (!uart_s) begin
            uart_level_live_r <= 1'b0;
        end else if (txd_s) begin
            uart_level_live_r <= 1'b1;                                   // RULE18
        end
    end

    // Regulator level selection
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_regulator_level <= 2'b00;
        end else if (uart_s && uart_level_live_r) begin
            o_regulator_level <= io_r[`UVCR_IO_UREG_MSB:`UVCR_IO_UREG_LSB]; // RULE18
        end else if (!uart_s) begin
            o_regulator_level <= io_r[`UVCR_IO_SREG_MSB:`UVCR_IO_SREG_LSB]; // RULE19
        end
    end

    // Pin swap and pull-ups
    assign o_data_pin_swap        = io_r[`UVCR_IO_SWAP];                 // RULE17
    assign o_dp_charger_pullup_en = io_r[`UVCR_IO_PU_DP] || uart_s;      // RULE20
    assign o_dm_charger_pullup_en = io_r[`UVCR_IO_PU_DM] || uart_s;      // RULE20

    // Read data mux, registered
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            if (hit_chg) begin
                o_reg_rdata <= {3'h0, det_r, chg_r};
            end else if (hit_id) begin
                o_reg_rdata <= {1'b0, id_r[6:0]};
            end else if (hit_io) begin
                o_reg_rdata <= io_r;
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end
endmodule // uvcr_regs

//--- dv/uvcr_checker.sv
/* Assertion checker for the vendor register bank, bound to uvcr_regs.
   Assumes only the bank's own ports and the bank's CONV_CYC conversion length. */
module uvcr_checker #(
    parameter int CONV_CYC = 28200 // Conversion length in cycles
) (
    // Clock, reset and register access
    input wire logic       i_mclk, i_arst_n, i_reg_wr, i_reg_rd, o_reg_hit,
    input wire logic [5:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata, o_reg_rdata,
    // Carkit side, modes and analog controls
    input wire logic       i_carkit_irq_en, i_carkit_status_rd, o_carkit_dat_detect,
    input wire logic       o_carkit_id_done, o_alt_int, i_uart_mode, o_id_conversion_busy,
    input wire logic       o_dp_dat_sink_en, o_dm_dat_sink_en, o_data_pin_swap,
    input wire logic       o_dp_dat_source_voltage_en, o_dm_dat_source_voltage_en,
    input wire logic       o_dp_charger_pullup_en, o_dm_charger_pullup_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    logic [15:0] busy_cnt_r; // Length of the running conversion
    // Counts busy cycles so the conversion time can be judged
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) busy_cnt_r <= 16'h0;
        else busy_cnt_r <= o_id_conversion_busy ? busy_cnt_r + 16'h1 : 16'h0;
    end
    a_sink_gates_det: assert property ((!(o_dp_dat_sink_en || o_dm_dat_sink_en))[*3]
        |-> !o_carkit_dat_detect) else $error("detect set with sink off");
    a_host_one_pin: assert property (!(o_dp_dat_sink_en && o_dm_dat_sink_en)
        && !(o_dp_dat_source_voltage_en && o_dm_dat_source_voltage_en))
        else $error("charger control on both pins");
    a_conv_length: assert property ($fell(o_id_conversion_busy)
        |-> busy_cnt_r >= CONV_CYC - 1 && busy_cnt_r <= CONV_CYC + 1)
        else $error("conversion length wrong");
    a_done_at_end: assert property ($fell(o_id_conversion_busy)
        |-> ##[0:1] o_carkit_id_done) else $error("done missing at end");
    a_irq_needs_done: assert property (o_alt_int |-> o_carkit_id_done)
        else $error("alt int without done");
    a_irq_enable_or: assert property (o_carkit_id_done && i_carkit_irq_en |-> o_alt_int)
        else $error("carkit enable ignored");
    a_read_clears: assert property (i_reg_rd && i_reg_addr >= 6'h36
        && i_reg_addr <= 6'h38 && o_carkit_id_done && !o_id_conversion_busy
        |-> ##[1:2] !o_carkit_id_done)
        else $error("done not cleared by read");
    a_carkit_keeps: assert property (i_carkit_status_rd && o_carkit_id_done && !i_reg_rd
        |=> o_carkit_id_done) else $error("carkit read cleared done");
    a_swap_written: assert property (i_reg_wr && i_reg_addr == 6'h39
        |=> o_data_pin_swap == $past(i_reg_wdata[1])) else $error("swap not written");
    a_uart_pullups: assert property (i_uart_mode[*4]
        |-> o_dp_charger_pullup_en && o_dm_charger_pullup_en) else $error("uart pullups off");
    a_hit_decode: assert property (o_reg_hit == (i_reg_addr == 6'h32
        || (i_reg_addr >= 6'h36 && i_reg_addr <= 6'h3b))) else $error("hit decode wrong");
    a_unmapped_zero: assert property (i_reg_rd && !o_reg_hit |-> ##2 o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    c_conv_done: cover property ($fell(o_id_conversion_busy));
    c_alt_int: cover property (o_alt_int);
    c_detect: cover property (o_carkit_dat_detect);
endmodule // uvcr_checker

bind uvcr_regs uvcr_checker #(.CONV_CYC(CONV_CYC)) u_chk (.i_mclk, .i_arst_n, .i_reg_wr,
    .i_reg_rd, .o_reg_hit, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_carkit_irq_en,
    .i_carkit_status_rd, .o_carkit_dat_detect, .o_carkit_id_done, .o_alt_int, .i_uart_mode,
    .o_id_conversion_busy, .o_dp_dat_sink_en, .o_dm_dat_sink_en, .o_data_pin_swap,
    .o_dp_dat_source_voltage_en, .o_dm_dat_source_voltage_en, .o_dp_charger_pullup_en,
    .o_dm_charger_pullup_en);

//--- dv/uvcr_link_model.sv
/* Link-side model: issues immediate register writes and reads.
   Assumes strobes sampled on rising i_mclk; drives at falling edges. */
module uvcr_link_model (
    // Clock and read data
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rdata,
    // Register strobes
    output logic            o_wr,
    output logic            o_rd,
    output logic [5:0]      o_addr,
    output logic [7:0]      o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 6'h00;
        o_wdata = 8'h00;
    end
    // One-cycle write; data inverted once released
    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_wdata = (a >= 6'h36 && a <= 6'h38) ? (d & 8'hdf) : d;
        o_wr = 1'b1;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_wdata = ~o_wdata;
    endtask
    // One-cycle read; byte taken once settled
    task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_mclk);
        o_rd = 1'b0;
        @(negedge i_mclk);
        d = i_rdata;
    endtask
endmodule // uvcr_link_model

//--- dv/tb_top.sv
/* Self-checking bench for the vendor register bank.
   Assumes the link model for register traffic and a 20-cycle conversion. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 20; // Shortened conversion
    logic       i_mclk, i_arst_n, i_reg_wr, i_reg_rd, o_reg_hit, i_carkit_irq_en;
    logic       i_carkit_status_rd, o_carkit_dat_detect, o_carkit_id_done, o_alt_int;
    logic       i_uart_mode, i_uart_transmit_path_en, i_dp_voltage_seen, i_dm_voltage_seen;
    logic       o_id_conversion_busy, o_data_pin_swap, o_dp_charger_pullup_en;
    logic       o_dm_charger_pullup_en, o_dp_dat_source_voltage_en, o_dm_dat_source_voltage_en;
    logic       o_dp_dat_sink_en, o_dm_dat_sink_en, o_dp_contact_source_en, o_dm_contact_source_en;
    logic [1:0] i_linestate, o_regulator_level;
    logic [2:0] o_carkit_id_code, i_id_adc_code;
    logic [5:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, rd;
    int         miscompares = 0;
    int         tests_run = 0;
    uvcr_regs #(.CONV_CYC(CONV)) uut (.i_mclk, .i_arst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr,
        .i_reg_wdata, .o_reg_rdata, .o_reg_hit, .i_carkit_irq_en, .i_carkit_status_rd,
        .o_carkit_dat_detect, .o_carkit_id_code, .o_carkit_id_done, .o_alt_int, .i_uart_mode,
        .i_uart_transmit_path_en, .i_linestate, .i_dp_voltage_seen, .i_dm_voltage_seen,
        .i_id_adc_code, .o_dp_dat_source_voltage_en, .o_dm_dat_source_voltage_en,
        .o_dp_dat_sink_en, .o_dm_dat_sink_en, .o_dp_contact_source_en, .o_dm_contact_source_en,
        .o_id_conversion_busy, .o_data_pin_swap, .o_dp_charger_pullup_en,
        .o_dm_charger_pullup_en, .o_regulator_level);
    uvcr_link_model link (.i_mclk, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
        .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    // Free-running clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        link.reg_write(a, d);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string what);
        link.reg_read(a, rd);
        chk(rd, e, what);
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // Bounded wait for the conversion to end
    task automatic wait_conv;
        int n;
        n = 0;
        while (o_id_conversion_busy !== 1'b0 && n < 200) begin
            @(negedge i_mclk);
            n++;
        end
        // A conversion that never ends is a failure, not a silent pass
        if (n >= 200) begin
            miscompares++;
            $display("[ERR] %0t conversion never ended", $time);
            tally_and_finish;
        end
        settle(2);
    endtask
    task automatic t_reset;
        rdc(6'h32, 8'h00, "chg reset");
        rdc(6'h38, 8'h00, "id reset");
        rdc(6'h39, 8'h04, "io reset");
        chk({6'h0, o_regulator_level}, 8'h00, "level reset");
        rdc(6'h33, 8'h00, "unmapped read");
        wr(6'h3c, 8'hff);
        rdc(6'h3a, 8'h04, "unmapped write");
        $display("t_reset done");
    endtask
    task automatic t_charger;
        i_dp_voltage_seen = 1'b1;
        wr(6'h32, 8'h05);
        chk({4'h0, o_dp_dat_source_voltage_en, o_dm_dat_source_voltage_en,
            o_dp_contact_source_en, o_dm_contact_source_en}, 8'h0a, "dp sources");
        wr(6'h32, 8'hff);
        chk({6'h0, o_dp_dat_sink_en, o_dm_dat_sink_en}, 8'h01, "host sink");
        settle(4);
        rdc(6'h32, 8'h0f, "host detect");
        wr(6'h32, 8'h02);
        settle(4);
        rdc(6'h32, 8'h12, "detect");
        chk({7'h0, o_carkit_dat_detect}, 8'h01, "detect mirror");
        i_linestate = 2'b01;
        settle(2);
        rdc(6'h32, 8'h02, "linestate");
        i_linestate = 2'b00;
        wr(6'h32, 8'h00);
        settle(2);
        rdc(6'h32, 8'h00, "sink off");
        $display("t_charger done");
    endtask
    task automatic t_idconv;
        i_id_adc_code = 3'h5;
        settle(3);
        wr(6'h37, 8'h10);
        rdc(6'h36, 8'h10, "go set");
        wait_conv;
        chk({3'h0, o_carkit_id_done, o_alt_int, o_carkit_id_code}, 8'h15, "done");
        i_carkit_status_rd = 1'b1;
        settle(1);
        i_carkit_status_rd = 1'b0;
        settle(1);
        chk({7'h0, o_carkit_id_done}, 8'h01, "carkit read");
        rdc(6'h38, 8'h0d, "code read");
        chk({7'h0, o_carkit_id_done}, 8'h00, "done clear");
        wr(6'h36, 8'h40);
        i_id_adc_code = 3'h6;
        settle(3);
        wr(6'h37, 8'h10);
        wait_conv;
        chk({7'h0, o_alt_int}, 8'h01, "irq");
        rdc(6'h37, 8'h4f, "err code");
        chk({7'h0, o_alt_int}, 8'h00, "irq clear");
        wr(6'h38, 8'h40);
        rdc(6'h36, 8'h07, "clear en");
        i_carkit_irq_en = 1'b1;
        wr(6'h36, 8'h10);
        wait_conv;
        chk({7'h0, o_alt_int}, 8'h01, "carkit en");
        i_carkit_irq_en = 1'b0;
        settle(1);
        chk({7'h0, o_alt_int}, 8'h00, "carkit off");
        rdc(6'h36, 8'h0f, "final");
        $display("t_idconv done");
    endtask
    task automatic t_io;
        wr(6'h39, 8'hff);
        rdc(6'h39, 8'hfe, "io write");
        chk({5'h0, o_data_pin_swap, o_dp_charger_pullup_en, o_dm_charger_pullup_en},
            8'h07, "io on");
        wr(6'h3b, 8'h32);
        rdc(6'h3a, 8'hcc, "io clear");
        chk({5'h0, o_data_pin_swap, o_dp_charger_pullup_en, o_dm_charger_pullup_en},
            8'h00, "io off");
        chk({6'h0, o_regulator_level}, 8'h03, "usb level");
        wr(6'h39, 8'h84);
        settle(3);
        chk({6'h0, o_regulator_level}, 8'h02, "usb level 2");
        wr(6'h3a, 8'h03);
        rdc(6'h3b, 8'h86, "io set");
        chk({7'h0, o_data_pin_swap}, 8'h01, "swap set");
        i_uart_mode = 1'b1;
        settle(5);
        chk({5'h0, o_regulator_level, o_dp_charger_pullup_en}, 8'h05, "uart hold");
        i_uart_transmit_path_en = 1'b1;
        settle(5);
        chk({6'h0, o_regulator_level}, 8'h01, "uart level");
        i_uart_mode = 1'b0;
        i_uart_transmit_path_en = 1'b0;
        settle(5);
        chk({6'h0, o_regulator_level}, 8'h02, "usb back");
        $display("t_io done");
    endtask
    // Verdict and end of run
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        {i_carkit_irq_en, i_carkit_status_rd, i_uart_mode, i_uart_transmit_path_en} = 4'h0;
        {i_dp_voltage_seen, i_dm_voltage_seen, i_linestate, i_id_adc_code} = 7'h0;
        i_arst_n = 1'b0;
        settle(8);
        i_arst_n = 1'b1;
        t_reset;
        t_charger;
        t_idconv;
        t_io;
        tally_and_finish;
    end
    // Watchdog
    initial begin
        #100us;
        miscompares++;
        tally_and_finish;
    end
endmodule // tb_top
